// ---- inc/secx_pkg.sv ----
// Package of constants and carriers for the subroutine, clear and complement executor
package secx_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] SECX_OFF_EXEC   = 8'h00;
   localparam logic [7:0] SECX_OFF_WORK   = 8'h04;
   localparam logic [7:0] SECX_OFF_PC_HIGH_LATCH = 8'h08;
   localparam logic [7:0] SECX_OFF_PC     = 8'h0C;
   localparam logic [7:0] SECX_OFF_STATUS = 8'h10;
   localparam logic [7:0] SECX_OFF_FADDR  = 8'h14;
   localparam logic [7:0] SECX_OFF_FDATA  = 8'h18;
   localparam logic [7:0] SECX_OFF_STACK  = 8'h1C;
   localparam logic [7:0] SECX_OFF_WDT    = 8'h20;
   localparam logic [7:0] SECX_OFF_CTRL   = 8'h24;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned SECX_ST_Z_BIT    = 0;
   localparam int unsigned SECX_ST_PDN_BIT  = 1;
   localparam int unsigned SECX_ST_TON_BIT  = 2;
   localparam int unsigned SECX_ST_BUSY_BIT = 8;
   localparam int unsigned SECX_CTRL_WEN    = 0;
   localparam int unsigned SECX_STK_PTR_LSB = 16;
   localparam int unsigned SECX_WDT_PRE_LSB = 16;

   // ----------------------------------------------------------------
   // Reset values and constants
   // ----------------------------------------------------------------
   localparam logic [7:0]  SECX_WORK_RST   = 8'h00;
   localparam logic [4:0]  SECX_PC_HIGH_LATCH_RST = 5'h00;
   localparam logic [12:0] SECX_PC_RST     = 13'h0000;
   localparam logic        SECX_FLAG_N_RST = 1'b1;
   localparam logic [31:0] SECX_RD_ZERO    = 32'h00000000;
   localparam logic [12:0] SECX_PC_STEP    = 13'h0001;
   localparam logic [7:0]  SECX_BYTE_ONE   = 8'h01;
   localparam logic [7:0]  SECX_BYTE_ZERO  = 8'h00;

   // ----------------------------------------------------------------
   // Operations and states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      SECX_OP_NOP        = 4'h0,
      SECX_OP_CALL       = 4'h1,
      SECX_OP_CLEAR_FILE = 4'h2,
      SECX_OP_CLEAR_WORK = 4'h3,
      SECX_OP_WDT_CLEAR  = 4'h4,
      SECX_OP_COMPLEMENT = 4'h5,
      SECX_OP_DECREMENT  = 4'h6
   } secx_op_t;

   typedef enum logic [1:0] {
      SECX_S_IDLE  = 2'b00,
      SECX_S_EXEC  = 2'b01,
      SECX_S_CALL2 = 2'b11
   } secx_state_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0]  rsv_hi;
      logic [10:0] k;
      logic [3:0]  rsv_lo;
      logic [6:0]  f;
      logic        d;
      logic [3:0]  op;
   } secx_instr_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } secx_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } secx_apb_rsp_t;

endpackage : secx_pkg

// ---- design/secx_core.sv ----
// Executor for call, clear, watchdog clear, complement and decrement
//
// Overview of operation
// - Call pushes program counter plus one
// - Call loads eleven-bit target into low bits
// - Call fills top bits from latch bits 4:3
// - Call takes two cycles, flags untouched
// - Clear file register writes zero, sets zero
// - Clear working register writes zero, sets zero
// - Watchdog clear zeroes the watchdog counter
// - Watchdog clear zeroes the prescaler too
// - Watchdog clear sets timeout and power-down flags
// - Complement inverts register, destination bit selects
// - Decrement subtracts one, destination bit selects
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps

module secx_core
   import secx_pkg::*;
#(
   parameter int unsigned STACK_DEPTH = 8,
   parameter int unsigned FILE_WORDS  = 128,
   parameter int unsigned WDT_W       = 8,
   parameter int unsigned PRE_W       = 8
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          pce,
   input  wire secx_apb_req_t apb_req,
   output secx_apb_rsp_t      apb_rsp
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   localparam int unsigned SP_W = $clog2(STACK_DEPTH);

   typedef struct packed {
      secx_state_t                       state;
      secx_instr_t                       instr;
      logic [7:0]                        work;
      logic [4:0]                        pc_high_latch;
      logic [12:0]                       pc;
      logic                              z;
      logic                              timeout_flag_n;
      logic                              power_down_flag_n;
      logic [6:0]                        faddr;
      logic [FILE_WORDS-1:0][7:0]        file;
      logic [STACK_DEPTH-1:0][12:0]      stack;
      logic [SP_W-1:0]                   sp;
      logic [WDT_W-1:0]                  watchdog_counter;
      logic [PRE_W-1:0]                  wdt_pre;
      logic                              wdt_en;
      logic [31:0]                       prdata;
   } secx_regs_t;

   localparam secx_regs_t SECX_RST = '{
      state:             SECX_S_IDLE,
      instr:             '0,
      work:              SECX_WORK_RST,
      pc_high_latch:            SECX_PC_HIGH_LATCH_RST,
      pc:                SECX_PC_RST,
      z:                 1'b0,
      timeout_flag_n:    SECX_FLAG_N_RST,
      power_down_flag_n: SECX_FLAG_N_RST,
      faddr:             '0,
      file:              '0,
      stack:             '0,
      sp:                '0,
      watchdog_counter:  '0,
      wdt_pre:           '0,
      wdt_en:            1'b0,
      prdata:            SECX_RD_ZERO
   };

   secx_regs_t s;
   secx_regs_t next_s;

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   function automatic logic secx_mapped(input logic [7:0] a);
      unique case (a)
         SECX_OFF_EXEC,
         SECX_OFF_WORK,
         SECX_OFF_PC_HIGH_LATCH,
         SECX_OFF_PC,
         SECX_OFF_STATUS,
         SECX_OFF_FADDR,
         SECX_OFF_FDATA,
         SECX_OFF_STACK,
         SECX_OFF_WDT,
         SECX_OFF_CTRL: secx_mapped = 1'b1;
         default:       secx_mapped = 1'b0;
      endcase
   endfunction

   function automatic logic secx_dest_file(input secx_instr_t i);
      secx_dest_file = i.d;
   endfunction

   // ----------------------------------------------------------------
   // Combinational signals
   // ----------------------------------------------------------------
   logic            setup_ph;
   logic            access_ph;
   logic            access_wr;
   logic            busy;
   logic [SP_W-1:0] sp_top;
   logic [7:0]      f_val;
   logic [7:0]      result;
   logic            pre_wrap;
   logic            wdt_wrap;
   logic [31:0]     rd_mux;
   logic [12:0]     pc_plus;
   logic            result_zero;

   assign busy      = (s.state != SECX_S_IDLE);
   assign setup_ph  = apb_req.psel & ~apb_req.penable;
   assign access_ph = apb_req.psel & apb_req.penable;
   assign access_wr = access_ph & apb_req.pwrite & pce;
   assign sp_top    = s.sp - SP_W'(1);
   assign f_val     = s.file[s.instr.f];
   assign pre_wrap  = s.wdt_en & (&s.wdt_pre);
   assign wdt_wrap  = pre_wrap & (&s.watchdog_counter);
   assign pc_plus   = s.pc + SECX_PC_STEP;
   assign result_zero = (result == SECX_BYTE_ZERO);

   // ----------------------------------------------------------------
   // Bus response
   // ----------------------------------------------------------------
   always_comb begin
      apb_rsp.prdata  = s.prdata;
      apb_rsp.pready  = pce;
      apb_rsp.pslverr = access_ph & ~secx_mapped(apb_req.paddr);
   end

   always_comb begin
      rd_mux = SECX_RD_ZERO;
      unique case (apb_req.paddr)
         SECX_OFF_EXEC: begin
            rd_mux = s.instr;
         end
         SECX_OFF_WORK: begin
            rd_mux[7:0] = s.work;
         end
         SECX_OFF_PC_HIGH_LATCH: begin
            rd_mux[4:0] = s.pc_high_latch;
         end
         SECX_OFF_PC: begin
            rd_mux[12:0] = s.pc;
         end
         SECX_OFF_STATUS: begin
            rd_mux[SECX_ST_Z_BIT]    = s.z;
            rd_mux[SECX_ST_PDN_BIT]  = s.power_down_flag_n;
            rd_mux[SECX_ST_TON_BIT]  = s.timeout_flag_n;
            rd_mux[SECX_ST_BUSY_BIT] = busy;
         end
         SECX_OFF_FADDR: begin
            rd_mux[6:0] = s.faddr;
         end
         SECX_OFF_FDATA: begin
            rd_mux[7:0] = s.file[s.faddr];
         end
         SECX_OFF_STACK: begin
            rd_mux[12:0]                            = s.stack[sp_top];
            rd_mux[SECX_STK_PTR_LSB +: SP_W]        = s.sp;
         end
         SECX_OFF_WDT: begin
            rd_mux[WDT_W-1:0]                       = s.watchdog_counter;
            rd_mux[SECX_WDT_PRE_LSB +: PRE_W]       = s.wdt_pre;
         end
         SECX_OFF_CTRL: begin
            rd_mux[SECX_CTRL_WEN] = s.wdt_en;
         end
         default: begin
            rd_mux = SECX_RD_ZERO;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Operation result
   // ----------------------------------------------------------------
   always_comb begin
      unique case (secx_op_t'(s.instr.op))
         SECX_OP_COMPLEMENT: begin
            result = ~f_val;
         end
         SECX_OP_DECREMENT: begin
            result = f_val - SECX_BYTE_ONE;
         end
         default: begin
            result = SECX_BYTE_ZERO;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;

      // Read data captured in the setup cycle
      if (setup_ph && !apb_req.pwrite) begin
         next_s.prdata = rd_mux;
      end

      // Register writes, refused while an instruction runs
      if (access_wr && !busy) begin
         unique case (apb_req.paddr)
            SECX_OFF_EXEC: begin
               next_s.instr = apb_req.pwdata;
               next_s.state = SECX_S_EXEC;
            end
            SECX_OFF_WORK: begin
               next_s.work = apb_req.pwdata[7:0];
            end
            SECX_OFF_PC_HIGH_LATCH: begin
               next_s.pc_high_latch = apb_req.pwdata[4:0];
            end
            SECX_OFF_PC: begin
               next_s.pc = apb_req.pwdata[12:0];
            end
            SECX_OFF_STATUS: begin
               next_s.z                 = apb_req.pwdata[SECX_ST_Z_BIT];
               next_s.power_down_flag_n = apb_req.pwdata[SECX_ST_PDN_BIT];
               next_s.timeout_flag_n    = apb_req.pwdata[SECX_ST_TON_BIT];
            end
            SECX_OFF_FADDR: begin
               next_s.faddr = apb_req.pwdata[6:0];
            end
            SECX_OFF_FDATA: begin
               next_s.file[s.faddr] = apb_req.pwdata[7:0];
            end
            SECX_OFF_CTRL: begin
               next_s.wdt_en = apb_req.pwdata[SECX_CTRL_WEN];
            end
            default: begin
            end
         endcase
      end

      // Watchdog prescaler and counter
      if (s.wdt_en) begin
         next_s.wdt_pre = s.wdt_pre + PRE_W'(1);
         if (pre_wrap) begin
            next_s.watchdog_counter = s.watchdog_counter + WDT_W'(1);
         end
      end

      // Instruction sequencer
      unique case (s.state)
         SECX_S_IDLE: begin
         end
         SECX_S_EXEC: begin
            next_s.state = SECX_S_IDLE;
            next_s.pc    = pc_plus;
            unique case (secx_op_t'(s.instr.op))
               SECX_OP_CALL: begin
                  next_s.stack[s.sp] = pc_plus;
                  next_s.sp          = s.sp + SP_W'(1);
                  next_s.state       = SECX_S_CALL2;
                  next_s.pc          = s.pc;
               end
               SECX_OP_CLEAR_FILE: begin
                  next_s.file[s.instr.f] = SECX_BYTE_ZERO;
                  next_s.z               = 1'b1;
               end
               SECX_OP_CLEAR_WORK: begin
                  next_s.work = SECX_BYTE_ZERO;
                  next_s.z    = 1'b1;
               end
               SECX_OP_WDT_CLEAR: begin
                  next_s.watchdog_counter  = '0;
                  next_s.wdt_pre           = '0;
                  next_s.timeout_flag_n    = 1'b1;
                  next_s.power_down_flag_n = 1'b1;
               end
               SECX_OP_COMPLEMENT: begin
                  if (secx_dest_file(s.instr)) begin
                     next_s.file[s.instr.f] = result;
                  end else begin
                     next_s.work = result;
                  end
                  next_s.z = result_zero;
               end
               SECX_OP_DECREMENT: begin
                  if (secx_dest_file(s.instr)) begin
                     next_s.file[s.instr.f] = result;
                  end else begin
                     next_s.work = result;
                  end
                  next_s.z = result_zero;
               end
               default: begin
               end
            endcase
         end
         SECX_S_CALL2: begin
            next_s.pc[10:0]  = s.instr.k;
            next_s.pc[12:11] = s.pc_high_latch[4:3];
            next_s.state     = SECX_S_IDLE;
         end
         default: begin
            next_s.state = SECX_S_IDLE;
         end
      endcase

      // Timeout event wins over any flag write
      if (wdt_wrap) begin
         next_s.timeout_flag_n = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= SECX_RST;
      end else if (pce) begin
         s <= next_s;
      end
   end

endmodule // secx_core

// ---- dv/secx_core_checker.sv ----
// Port checker for the executor
`timescale 1ns/1ps

module secx_core_checker
   import secx_pkg::*;
#(
   parameter int unsigned STACK_DEPTH = 8,
   parameter int unsigned FILE_WORDS  = 128,
   parameter int unsigned WDT_W       = 8,
   parameter int unsigned PRE_W       = 8
) (
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          pce,
   input wire secx_apb_req_t apb_req,
   input wire secx_apb_rsp_t apb_rsp
);
   // ------------------------------
   // Shadow of the last write
   // ------------------------------
   logic        wr_done;
   logic        st_idle;
   logic        exec_done;
   logic        last_exec;
   logic [3:0]  last_op;
   logic [10:0] last_k;
   logic [4:0]  latch_sh;
   secx_instr_t ins;

   assign ins     = secx_instr_t'(apb_req.pwdata);
   assign wr_done = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
   assign st_idle = apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready &&
                    apb_req.paddr == SECX_OFF_STATUS && !apb_rsp.prdata[SECX_ST_BUSY_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_exec <= 1'h0;
         last_op   <= 4'h0;
         last_k    <= 11'h000;
         latch_sh  <= 5'h00;
         exec_done <= 1'h0;
      end else if (wr_done) begin
         exec_done <= 1'h0;
         last_exec <= (apb_req.paddr == SECX_OFF_EXEC);
         last_op   <= ins.op;
         last_k    <= ins.k;
         if (apb_req.paddr == SECX_OFF_PC_HIGH_LATCH) begin
            latch_sh <= apb_req.pwdata[4:0];
         end
      end else if (st_idle) begin
         exec_done <= 1'h1;
      end
   end

   // ------------------------------
   // Properties
   // ------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_rd(logic [7:0] a);
      apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready && apb_req.paddr == a;
   endsequence

   sequence s_after(logic [3:0] op);
      last_exec && last_op == op && exec_done;
   endsequence

   property p_ready_pce;
      apb_rsp.pready == pce;
   endproperty
   property p_err_access;
      apb_rsp.pslverr |-> apb_req.psel && apb_req.penable;
   endproperty
   property p_err_unmapped;
      apb_req.psel && apb_req.penable && apb_req.paddr > SECX_OFF_CTRL |-> apb_rsp.pslverr;
   endproperty
   property p_clr_zero;
      s_rd(SECX_OFF_STATUS) ##0 (s_after(SECX_OP_CLEAR_FILE) or s_after(SECX_OP_CLEAR_WORK)) |-> apb_rsp.prdata[0];
   endproperty
   property p_clear_work_reg_op_work;
      s_rd(SECX_OFF_WORK) ##0 s_after(SECX_OP_CLEAR_WORK) |-> apb_rsp.prdata[7:0] == 8'h00;
   endproperty
   property p_wdt_flags;
      s_rd(SECX_OFF_STATUS) ##0 s_after(SECX_OP_WDT_CLEAR) |-> apb_rsp.prdata[2:1] == 2'h3;
   endproperty
   property p_wdt_cnt;
      s_rd(SECX_OFF_WDT) ##0 s_after(SECX_OP_WDT_CLEAR) |-> apb_rsp.prdata[7:0] == 8'h00;
   endproperty
   property p_wdt_pre;
      s_rd(SECX_OFF_WDT) ##0 s_after(SECX_OP_WDT_CLEAR) |-> apb_rsp.prdata[23:21] == 3'h0;
   endproperty
   property p_call_pc;
      s_rd(SECX_OFF_PC) ##0 s_after(SECX_OP_CALL) |-> apb_rsp.prdata[12:0] == {latch_sh[4:3], last_k};
   endproperty

   a_ready_pce: assert property (p_ready_pce) else $error("pready differs from pce");
   a_err_access: assert property (p_err_access) else $error("pslverr outside access");
   a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
   a_clr_zero: assert property (p_clr_zero) else $error("zero flag not set by clear");
   a_clear_work_reg_op_work: assert property (p_clear_work_reg_op_work) else $error("working register not cleared");
   a_wdt_flags: assert property (p_wdt_flags) else $error("status flags not set");
   a_wdt_cnt: assert property (p_wdt_cnt) else $error("watchdog counter not cleared");
   a_wdt_pre: assert property (p_wdt_pre) else $error("prescaler not cleared");
   a_call_pc: assert property (p_call_pc) else $error("call target wrong");
endmodule // secx_core_checker

bind secx_core secx_core_checker #(
   .STACK_DEPTH (STACK_DEPTH),
   .FILE_WORDS  (FILE_WORDS),
   .WDT_W       (WDT_W),
   .PRE_W       (PRE_W)
) u_chk (
   .pclk    (pclk),
   .presetn (presetn),
   .pce     (pce),
   .apb_req (apb_req),
   .apb_rsp (apb_rsp)
);

// ---- dv/test_secx_core.sv ----
// Self-checking bench for the executor
`timescale 1ns/1ps

module test_secx_core
   import secx_pkg::*;
;
   logic          pclk;
   logic          presetn;
   logic          pce;
   secx_apb_req_t req;
   secx_apb_rsp_t rsp;
   int            failures;
   int            total_checks;
   logic [31:0]   rd;
   logic          err;
   int            polls;

   secx_core dut_u (
      .pclk    (pclk),
      .presetn (presetn),
      .pce     (pce),
      .apb_req (req),
      .apb_rsp (rsp)
   );

   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic report_and_stop;
      $display("Checks: %0d, mismatches: %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t ns: got %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      req.psel    <= 1'h1;
      req.penable <= 1'h0;
      req.pwrite  <= wr;
      req.paddr   <= a;
      req.pwdata  <= wd;
      @(posedge pclk);
      req.penable <= 1'h1;
      @(posedge pclk);
      while (rsp.pready !== 1'h1) @(posedge pclk);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel    <= 1'h0;
      req.penable <= 1'h0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h00000000);
      check(rd, exp);
   endtask

   task automatic exec(input logic [3:0] op, input logic d, input logic [6:0] f, input logic [10:0] k);
      int n;
      apb(1'h1, SECX_OFF_EXEC, secx_instr_t'{5'h00, k, 4'h0, f, d, op});
      n = 0;
      do begin
         apb(1'h0, SECX_OFF_STATUS, 32'h00000000);
         n++;
      end while (rd[SECX_ST_BUSY_BIT] !== 1'h0 && n < 20);
      polls = n;
      check(rd & 32'h00000100, 32'h00000000);
   endtask

   // ------------------------------
   // Clock, watchdog and tests
   // ------------------------------
   initial begin
      pclk = 1'h0;
      forever #25 pclk = ~pclk;
   end

   initial begin
      #1000000;
      failures++;
      $display("Error at %0t ns: timeout", $time);
      report_and_stop;
   end

   initial begin
      logic [7:0] ini;
      logic [7:0] res;
      logic       zf;
      presetn = 1'h0;
      pce = 1'h1;
      req = '0;
      failures = 0;
      total_checks = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      rdc(SECX_OFF_STATUS, 32'h00000006);
      apb(1'h0, 8'h40, 32'h00000000);
      check({31'h0, err}, 32'h00000001);
      check(rd, SECX_RD_ZERO);
      apb(1'h1, SECX_OFF_PC_HIGH_LATCH, 32'h00000018);
      apb(1'h1, SECX_OFF_PC, 32'h00000123);
      apb(1'h1, SECX_OFF_STATUS, 32'h00000005);
      exec(SECX_OP_CALL, 1'h0, 7'h00, 11'h7FF);
      check(polls, 32'h00000002);
      rdc(SECX_OFF_PC, 32'h00001FFF);
      rdc(SECX_OFF_STACK, 32'h00010124);
      rdc(SECX_OFF_STATUS, 32'h00000005);
      apb(1'h1, SECX_OFF_PC_HIGH_LATCH, 32'h0000000F);
      exec(SECX_OP_CALL, 1'h0, 7'h00, 11'h000);
      rdc(SECX_OFF_PC, 32'h00000800);
      apb(1'h1, SECX_OFF_STACK, 32'hFFFFFFFF);
      rdc(SECX_OFF_STACK, 32'h00020000);
      apb(1'h1, SECX_OFF_FADDR, 32'h0000007F);
      apb(1'h1, SECX_OFF_FDATA, 32'h0000005A);
      apb(1'h1, SECX_OFF_STATUS, 32'h00000006);
      exec(SECX_OP_CLEAR_FILE, 1'h0, 7'h7F, 11'h000);
      check(polls, 32'h00000001);
      rdc(SECX_OFF_FDATA, 32'h00000000);
      rdc(SECX_OFF_STATUS, 32'h00000007);
      apb(1'h1, SECX_OFF_WORK, 32'h000000A5);
      apb(1'h1, SECX_OFF_STATUS, 32'h00000006);
      exec(SECX_OP_CLEAR_WORK, 1'h0, 7'h00, 11'h000);
      rdc(SECX_OFF_WORK, 32'h00000000);
      rdc(SECX_OFF_STATUS, 32'h00000007);
      apb(1'h1, SECX_OFF_CTRL, 32'h00000001);
      apb(1'h1, SECX_OFF_STATUS, 32'h00000000);
      repeat (300) @(posedge pclk);
      exec(SECX_OP_WDT_CLEAR, 1'h0, 7'h00, 11'h000);
      apb(1'h0, SECX_OFF_WDT, 32'h00000000);
      check(rd & 32'h00E000FF, 32'h00000000);
      rdc(SECX_OFF_STATUS, 32'h00000006);
      for (int i = 0; i < 4; i++) begin
         ini = (i == 0) ? 8'hFF : (i == 1) ? 8'h0F : (i == 2) ? 8'h01 : 8'h00;
         res = (i < 2) ? ~ini : ini - 8'h01;
         zf = (res == 8'h00);
         apb(1'h1, SECX_OFF_FADDR, 32'h00000011);
         apb(1'h1, SECX_OFF_FDATA, {24'h0, ini});
         apb(1'h1, SECX_OFF_WORK, 32'h00000033);
         apb(1'h1, SECX_OFF_STATUS, {29'h0, 2'h3, ~zf});
         exec((i < 2) ? SECX_OP_COMPLEMENT : SECX_OP_DECREMENT, i[0], 7'h11, 11'h000);
         rdc(SECX_OFF_WORK, {24'h0, i[0] ? 8'h33 : res});
         rdc(SECX_OFF_FDATA, {24'h0, i[0] ? res : ini});
         rdc(SECX_OFF_STATUS, {29'h0, 2'h3, zf});
      end
      // Clock enable low freezes the prescaler
      apb(1'h0, SECX_OFF_WDT, 32'h00000000);
      ini = rd[23:16];
      pce <= 1'h0;
      repeat (10) @(posedge pclk);
      check({31'h0, rsp.pready}, 32'h00000000);
      pce <= 1'h1;
      apb(1'h0, SECX_OFF_WDT, 32'h00000000);
      res = rd[23:16] - ini;
      check({24'h0, res}, 32'h00000003);
      report_and_stop;
   end
endmodule // test_secx_core
